// ### hdl/slc_pkg.sv
// register map, field layout and reset values of the link config bank
// assumes a word-indexed register port: one address step per register
package slc_pkg;
    localparam int          SLC_LINKS      = 8;
    localparam int          SLC_AW         = 8;
    localparam int          SLC_IDLE_W     = 11;
    localparam int          SLC_CHAN_W     = 5;
    // register indices
    localparam logic [7:0]  SLC_STAT_BASE  = 8'h20;
    localparam logic [7:0]  SLC_CFG_BASE   = 8'h80;
    localparam logic [7:0]  SLC_STF_BASE   = 8'hA0;
    localparam logic [7:0]  SLC_IRQ_STAT   = 8'hC0;
    localparam logic [7:0]  SLC_IRQ_MASK   = 8'hC1;
    // link config fields
    localparam int          SLC_EN_BIT     = 31;
    localparam int          SLC_WIRE5_BIT  = 30;
    localparam int          SLC_ERR_BIT    = 27;
    localparam int          SLC_ISSUED_BIT = 26;
    localparam int          SLC_HELD_BIT   = 25;
    localparam int          SLC_CRST_BIT   = 24;
    localparam int          SLC_RRST_BIT   = 23;
    localparam int          SLC_IDLE_LSB   = 11;
    localparam int          SLC_LOW_W      = 11;
    // static forwarding fields
    localparam int          SLC_STF_EN_BIT = 31;
    localparam int          SLC_PROC_BIT   = 8;
    // status fields
    localparam int          SLC_SRC_BIT    = 0;
    localparam int          SLC_DST_BIT    = 1;
    localparam int          SLC_JUNK_BIT   = 2;
    // reset values
    localparam logic        SLC_EN_RST     = 1'b0;
    localparam logic [7:0]  SLC_MASK_RST   = 8'h00;
    // static slot order: C, D, A, B, G, H, E, F as link numbers
    localparam logic [23:0] SLC_STF_ORDER  = {3'd5, 3'd4, 3'd7, 3'd6, 3'd1, 3'd0, 3'd3, 3'd2};
endpackage

// ### hdl/slc_link_cfg.sv
// link configuration, credit control and static forwarding register bank
// assumes link engines on sys_clk_i; their event inputs are single-cycle pulses
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - link enable bit turns link on/off
// - link enable also hands shared pins to link
// - wire-mode bit: 0 two-wire, 1 five-wire
// - sticky error on overflow or illegal token
// - read-only bit: credit issued to remote
// - read-only bit: credit held from remote
// - credit reset clears credit, sends greeting token
// - receiver reset restarts token symbol framing
// - 11-bit idle gap field, count minus one
// - one config register per link 0..7
// - static enable forwards all traffic unrouted
// - one-bit destination processor select
// - five-bit destination channel end select
// - static registers map to C,D,A,B,G,H,E,F
// - two-wire link: two wires each direction
// - status bits: source, dest in use, junk
module slc_link_cfg
    import slc_pkg::*;
#(
    parameter int LINKS = SLC_LINKS
) (
    input  wire logic                       sys_clk_i,
    input  wire logic                       rstn_i,
    input  wire logic [SLC_AW-1:0]          addr_i,
    input  wire logic [31:0]                wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [31:0]                rdata_o,
    input  wire logic [LINKS-1:0]           rx_overflow_i,
    input  wire logic [LINKS-1:0]           rx_illegal_i,
    input  wire logic [LINKS-1:0]           credit_issued_i,
    input  wire logic [LINKS-1:0]           credit_grant_i,
    input  wire logic [LINKS-1:0]           src_busy_i,
    input  wire logic [LINKS-1:0]           dst_busy_i,
    input  wire logic [LINKS-1:0]           junk_i,
    output logic      [LINKS-1:0]           link_en_o,
    output logic      [LINKS-1:0]           pin_mux_link_o,
    output logic      [LINKS-1:0]           five_wire_o,
    output logic      [LINKS*SLC_IDLE_W-1:0] idle_gap_o,
    output logic      [LINKS-1:0]           credit_reset_o,
    output logic      [LINKS-1:0]           greeting_token_o,
    output logic      [LINKS-1:0]           rx_reset_o,
    output logic      [LINKS-1:0]           static_en_o,
    output logic      [LINKS-1:0]           static_proc_o,
    output logic      [LINKS*SLC_CHAN_W-1:0] static_chan_o,
    output logic                            irq_o
);
    logic [LINKS-1:0]           wr_cfg;
    logic [LINKS-1:0]           wr_stf;
    logic [LINKS-1:0]           err_q;
    logic [LINKS-1:0]           issued_q;
    logic [LINKS-1:0]           held_q;
    logic [SLC_LOW_W-1:0]       low_q [LINKS];
    logic [LINKS-1:0]           irq_stat_q;
    logic [LINKS-1:0]           irq_mask_q;
    logic [31:0]                rdata_d;
    logic [LINKS-1:0]           err_evt;

    // static slot index to link number
    function automatic int stf_link(input int slot);
        return int'(SLC_STF_ORDER[slot*3 +: 3]);
    endfunction

    assign err_evt = rx_overflow_i | rx_illegal_i;

    always_comb begin
        for (int n = 0; n < LINKS; n++) begin
            wr_cfg[n] = wr_i && (addr_i == SLC_CFG_BASE + SLC_AW'(n));
            wr_stf[n] = wr_i && (addr_i == SLC_STF_BASE + SLC_AW'(n));
        end
    end

    // link control fields
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            link_en_o      <= {LINKS{SLC_EN_RST}};
            pin_mux_link_o <= {LINKS{SLC_EN_RST}};
            five_wire_o    <= '0;
            idle_gap_o     <= '0;
            for (int n = 0; n < LINKS; n++) begin
                low_q[n] <= '0;
            end
        end else begin
            for (int n = 0; n < LINKS; n++) begin
                if (wr_cfg[n]) begin
                    link_en_o[n]      <= wdata_i[SLC_EN_BIT];
                    pin_mux_link_o[n] <= wdata_i[SLC_EN_BIT];
                    // two-wire pairs per direction are the default pinout
                    five_wire_o[n]    <= wdata_i[SLC_WIRE5_BIT];
                    idle_gap_o[n*SLC_IDLE_W +: SLC_IDLE_W] <=
                        wdata_i[SLC_IDLE_LSB +: SLC_IDLE_W];
                    low_q[n]          <= wdata_i[SLC_LOW_W-1:0];
                end
            end
        end
    end

    // one-shot actions, never stored
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            credit_reset_o   <= '0;
            greeting_token_o <= '0;
            rx_reset_o       <= '0;
        end else begin
            for (int n = 0; n < LINKS; n++) begin
                credit_reset_o[n]   <= wr_cfg[n] && wdata_i[SLC_CRST_BIT];
                greeting_token_o[n] <= wr_cfg[n] && wdata_i[SLC_CRST_BIT];
                rx_reset_o[n]       <= wr_cfg[n] && wdata_i[SLC_RRST_BIT];
            end
        end
    end

    // credit state; a grant arriving with the clear wins
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            held_q   <= '0;
            issued_q <= '0;
        end else begin
            issued_q <= credit_issued_i;
            for (int n = 0; n < LINKS; n++) begin
                if (credit_grant_i[n]) begin
                    held_q[n] <= 1'b1;
                end else if (wr_cfg[n] && wdata_i[SLC_CRST_BIT]) begin
                    held_q[n] <= 1'b0;
                end
            end
        end
    end

    // error flag: sticky until the receiver is reset, new error wins
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            err_q <= '0;
        end else begin
            for (int n = 0; n < LINKS; n++) begin
                if (err_evt[n]) begin
                    err_q[n] <= 1'b1;
                end else if (wr_cfg[n] && wdata_i[SLC_RRST_BIT]) begin
                    err_q[n] <= 1'b0;
                end
            end
        end
    end

    // static forwarding, slot order differs from link order
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            static_en_o   <= '0;
            static_proc_o <= '0;
            static_chan_o <= '0;
        end else begin
            for (int s = 0; s < LINKS; s++) begin
                if (wr_stf[s]) begin
                    static_en_o[stf_link(s)]   <= wdata_i[SLC_STF_EN_BIT];
                    static_proc_o[stf_link(s)] <= wdata_i[SLC_PROC_BIT];
                    static_chan_o[stf_link(s)*SLC_CHAN_W +: SLC_CHAN_W] <=
                        wdata_i[SLC_CHAN_W-1:0];
                end
            end
        end
    end

    // interrupt: sticky error events, write one to clear, event wins
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            irq_stat_q <= '0;
            irq_mask_q <= SLC_MASK_RST[LINKS-1:0];
            irq_o      <= 1'b0;
        end else begin
            if (wr_i && addr_i == SLC_IRQ_MASK) begin
                irq_mask_q <= wdata_i[LINKS-1:0];
            end
            if (wr_i && addr_i == SLC_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~wdata_i[LINKS-1:0]) | err_evt;
            end else begin
                irq_stat_q <= irq_stat_q | err_evt;
            end
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        rdata_d = '0;
        for (int n = 0; n < LINKS; n++) begin
            if (addr_i == SLC_CFG_BASE + SLC_AW'(n)) begin
                rdata_d[SLC_EN_BIT]     = link_en_o[n];
                rdata_d[SLC_WIRE5_BIT]  = five_wire_o[n];
                rdata_d[SLC_ERR_BIT]    = err_q[n];
                rdata_d[SLC_ISSUED_BIT] = issued_q[n];
                rdata_d[SLC_HELD_BIT]   = held_q[n];
                rdata_d[SLC_IDLE_LSB +: SLC_IDLE_W] = idle_gap_o[n*SLC_IDLE_W +: SLC_IDLE_W];
                rdata_d[SLC_LOW_W-1:0]  = low_q[n];
            end
            if (addr_i == SLC_STAT_BASE + SLC_AW'(n)) begin
                rdata_d[SLC_SRC_BIT]  = src_busy_i[n];
                rdata_d[SLC_DST_BIT]  = dst_busy_i[n];
                rdata_d[SLC_JUNK_BIT] = junk_i[n];
            end
            if (addr_i == SLC_STF_BASE + SLC_AW'(n)) begin
                rdata_d[SLC_STF_EN_BIT] = static_en_o[stf_link(n)];
                rdata_d[SLC_PROC_BIT]   = static_proc_o[stf_link(n)];
                rdata_d[SLC_CHAN_W-1:0] = static_chan_o[stf_link(n)*SLC_CHAN_W +: SLC_CHAN_W];
            end
        end
        if (addr_i == SLC_IRQ_STAT) begin
            rdata_d[LINKS-1:0] = irq_stat_q;
        end
        if (addr_i == SLC_IRQ_MASK) begin
            rdata_d[LINKS-1:0] = irq_mask_q;
        end
    end

    // data only in the cycle after a read strobe
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rd_i ? rdata_d : '0;
        end
    end

    sequence s_crst_wr0;
        wr_cfg[0] && wdata_i[SLC_CRST_BIT];
    endsequence

    sequence s_pulse_once;
        credit_reset_o[0] && greeting_token_o[0];
    endsequence

    sequence s_rrst_wr1;
        wr_cfg[1] && wdata_i[SLC_RRST_BIT];
    endsequence

    a_link_enable: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_cfg[0] |=> link_en_o[0] == $past(wdata_i[SLC_EN_BIT]))
        else $error("link enable not taken");
    a_pin_mux: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        pin_mux_link_o == link_en_o)
        else $error("pin mux differs from enable");
    a_wire_mode: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_cfg[1] |=> five_wire_o[1] == $past(wdata_i[SLC_WIRE5_BIT]))
        else $error("wire mode not taken");
    a_err_sticky: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        err_evt[0] |=> err_q[0] [*1] ##0 (err_q[0] || $past(wr_cfg[0])))
        else $error("error flag lost");
    a_credit_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_crst_wr0 ##0 !credit_grant_i[0] |=>
            s_pulse_once ##0 !held_q[0] ##1 !credit_reset_o[0] || $past(wr_cfg[0]))
        else $error("credit reset sequence wrong");
    a_held_set: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        credit_grant_i[2] |=> held_q[2])
        else $error("held credit not set");
    a_rx_reset: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rx_reset_o[0] |-> $past(wr_cfg[0] && wdata_i[SLC_RRST_BIT]))
        else $error("spurious receiver reset");
    a_idle_gap: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_cfg[3] |=> idle_gap_o[3*SLC_IDLE_W +: SLC_IDLE_W] == $past(wdata_i[21:11]))
        else $error("idle gap not taken");
    a_static_map: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_stf[0] |=> static_en_o[2] == $past(wdata_i[SLC_STF_EN_BIT]))
        else $error("slot 0 not link C");
    a_read_window: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !$past(rd_i) |-> rdata_o == 32'h0000_0000)
        else $error("read data outside window");
    a_irq_level: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        ##1 irq_o == $past(|(irq_stat_q & irq_mask_q)))
        else $error("irq level wrong");

    a_en_last: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_cfg[7] |=> link_en_o[7] == $past(wdata_i[SLC_EN_BIT]))
        else $error("link 7 enable not taken");

    a_en_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !wr_cfg[0] |=> $stable(link_en_o[0]))
        else $error("link enable moved without write");

    a_mux_take: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_cfg[5] |=> pin_mux_link_o[5] == $past(wdata_i[SLC_EN_BIT]))
        else $error("pin mux not taken");

    a_wire_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !wr_cfg[1] |=> $stable(five_wire_o[1]))
        else $error("wire mode moved without write");

    a_err_ovf: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rx_overflow_i[6] |=> err_q[6])
        else $error("overflow not flagged");

    a_err_ill: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rx_illegal_i[6] |=> err_q[6])
        else $error("illegal token not flagged");

    a_err_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        err_q[4] && !(wr_cfg[4] && wdata_i[SLC_RRST_BIT]) |=> err_q[4])
        else $error("error flag dropped");

    a_err_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rd_i && addr_i == (SLC_CFG_BASE + 8'h05) |=> rdata_o[SLC_ERR_BIT] == $past(err_q[5]))
        else $error("error bit misread");

    a_issued_track: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        1'b1 |=> issued_q == $past(credit_issued_i))
        else $error("issued credit not tracked");

    a_issued_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rd_i && addr_i == (SLC_CFG_BASE + 8'h02) |=> rdata_o[SLC_ISSUED_BIT] == $past(issued_q[2]))
        else $error("issued bit misread");

    a_held_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rd_i && addr_i == (SLC_CFG_BASE + 8'h03) |=> rdata_o[SLC_HELD_BIT] == $past(held_q[3]))
        else $error("held bit misread");

    a_held_keep: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        held_q[3] && !(wr_cfg[3] && wdata_i[SLC_CRST_BIT]) |=> held_q[3])
        else $error("held credit dropped");

    a_greet_pair: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        greeting_token_o == credit_reset_o)
        else $error("greeting not paired with credit reset");

    a_crst_pulse: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        credit_reset_o[3] |=> !credit_reset_o[3] || $past(wr_cfg[3]))
        else $error("credit reset pulse too long");

    a_rrst_cause: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rx_reset_o[3] |-> $past(wr_cfg[3] && wdata_i[SLC_RRST_BIT]))
        else $error("spurious receiver reset on link 3");

    a_wo_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rd_i && addr_i == SLC_CFG_BASE |=> rdata_o[SLC_CRST_BIT:SLC_RRST_BIT] == 2'b00)
        else $error("action bits read back");

    a_rx_reset_on: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_rrst_wr1 |=> rx_reset_o[1])
        else $error("receiver reset not issued");

    a_idle_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !wr_cfg[3] |=> $stable(idle_gap_o[3*SLC_IDLE_W +: SLC_IDLE_W]))
        else $error("idle gap moved without write");

    a_idle_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rd_i && addr_i == (SLC_CFG_BASE + 8'h06) |=>
            rdata_o[21:11] == $past(idle_gap_o[6*SLC_IDLE_W +: SLC_IDLE_W]))
        else $error("idle gap misread");

    a_cfg_onehot: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $onehot0(wr_cfg))
        else $error("several link registers written");

    a_cfg_decode: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_cfg[7] |-> addr_i == (SLC_CFG_BASE + 8'h07))
        else $error("link 7 decode wrong");

    a_stf_en: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_stf[2] |=> static_en_o[0] == $past(wdata_i[SLC_STF_EN_BIT]))
        else $error("static enable not taken");

    a_stf_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !(|wr_stf) |=> $stable(static_en_o))
        else $error("static enable moved without write");

    a_stf_proc: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_stf[1] |=> static_proc_o[3] == $past(wdata_i[SLC_PROC_BIT]))
        else $error("static processor not taken");

    a_stf_chan: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_stf[4] |=> static_chan_o[6*SLC_CHAN_W +: SLC_CHAN_W] == $past(wdata_i[SLC_CHAN_W-1:0]))
        else $error("static channel not taken");

    a_stf_last: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_stf[7] |=> static_en_o[5] == $past(wdata_i[SLC_STF_EN_BIT]))
        else $error("slot 7 not link F");

    a_stat_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rd_i && addr_i == (SLC_STAT_BASE + 8'h04) |=>
            rdata_o[2:0] == $past({junk_i[4], dst_busy_i[4], src_busy_i[4]}))
        else $error("link status misread");

    a_irq_set: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        err_evt[1] |=> irq_stat_q[1])
        else $error("irq status not set");

    a_irq_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_i && addr_i == SLC_IRQ_STAT && wdata_i[5] && !err_evt[5] |=> !irq_stat_q[5])
        else $error("irq status not cleared");
endmodule

`default_nettype wire

// ### tb/slc_link_peer.sv
// far-side link engine model: turns bench requests into event pulses
// assumes requests are driven by nba right after sys_clk_i rises
`timescale 1ns/100ps
`default_nettype none
module slc_link_peer (
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] ovf_req_i,
    input  wire logic [7:0] ill_req_i,
    input  wire logic [7:0] lvl_i,
    input  wire logic [7:0] greeting_i,
    output logic      [7:0] rx_overflow_o,
    output logic      [7:0] rx_illegal_o,
    output logic      [7:0] credit_grant_o,
    output logic      [7:0] credit_issued_o
);
    logic [7:0] greet_q;
    // remote answers a greeting with fresh credit, two cycles late
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            greet_q <= 8'h00;
            credit_grant_o <= 8'h00;
            rx_overflow_o <= 8'h00;
            rx_illegal_o <= 8'h00;
            credit_issued_o <= 8'h00;
        end else begin
            greet_q <= greeting_i;
            credit_grant_o <= greet_q;
            rx_overflow_o <= ovf_req_i;
            rx_illegal_o <= ill_req_i;
            credit_issued_o <= lvl_i;
        end
    end
endmodule
`default_nettype wire

// ### tb/slc_link_cfg_tb.sv
// self-checking bench of the link config bank with a far-side model
// assumes word-indexed register port, read data one cycle after strobe
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module slc_link_cfg_tb;
    import slc_pkg::*;
    logic sys_clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, irq_o;
    logic [7:0] addr_i = 0, ovf = 0, ill = 0, lvl = 0, ovf_p, ill_p, iss, grant;
    logic [31:0] wdata_i = 0, rdata_o, d;
    logic [7:0] en, mux, w5, crst, greet, rrst, sen, sproc;
    logic [87:0] idle;
    logic [39:0] chan;
    int err_total = 0, n_compared = 0, cyc = 0;
    int lk[8] = '{2, 3, 0, 1, 6, 7, 4, 5};
    always #2.5 sys_clk_i = ~sys_clk_i;
    slc_link_peer slc_link_peer_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .ovf_req_i(ovf), .ill_req_i(ill), .lvl_i(lvl), .greeting_i(greet),
        .rx_overflow_o(ovf_p), .rx_illegal_o(ill_p), .credit_grant_o(grant),
        .credit_issued_o(iss));
    slc_link_cfg slc_link_cfg_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rx_overflow_i(ovf_p), .rx_illegal_i(ill_p), .credit_issued_i(iss),
        .credit_grant_i(grant), .src_busy_i(lvl), .dst_busy_i(~lvl), .junk_i(lvl),
        .link_en_o(en), .pin_mux_link_o(mux), .five_wire_o(w5), .idle_gap_o(idle),
        .credit_reset_o(crst), .greeting_token_o(greet), .rx_reset_o(rrst),
        .static_en_o(sen), .static_proc_o(sproc), .static_chan_o(chan), .irq_o(irq_o));
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic ev(input logic [7:0] o, input logic [7:0] i);
        @(posedge sys_clk_i);
        ovf <= o;
        ill <= i;
        @(posedge sys_clk_i);
        ovf <= 8'h00;
        ill <= 8'h00;
        repeat (3) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic t_cfg();
        logic [10:0] v;
        for (int n = 0; n < 8; n++) begin
            v = 11'(n * 200 + 1);
            wr(8'(SLC_CFG_BASE + n), {1'b1, n[0], 8'h00, v, 11'h7FF});
            `CHK(five_wire_o_bit(n), n[0])
            `CHK(idle[n*11+:11], v)
            rd(8'(SLC_CFG_BASE + n));
            `CHK(d, {1'b1, n[0], 8'h00, v, 11'h7FF})
        end
        `CHK({en, mux}, 16'hFFFF)
        // action bits set too: they must pulse and read back as zero
        wr(SLC_CFG_BASE, 32'hFFFF_FFFF);
        rd(SLC_CFG_BASE);
        `CHK(d, 32'hC03F_FFFF)
        for (int n = 0; n < 8; n++) wr(8'(SLC_CFG_BASE + n), 32'h0000_0000);
        `CHK({en, mux, w5}, 24'h00_0000)
    endtask
    function automatic logic five_wire_o_bit(input int n);
        return w5[n];
    endfunction
    task automatic t_act();
        repeat (2) begin
            wr(8'h83, 32'h0100_0000);
            `CHK({crst, greet}, 16'h0808)
            rd(8'h83);
            `CHK(d[25:23], 3'b000)
            `CHK({crst, greet}, 16'h0000)
            repeat (4) @(posedge sys_clk_i);
            rd(8'h83);
            `CHK(d[25], 1'b1)
        end
        wr(8'h83, 32'h0080_0000);
        `CHK(rrst, 8'h08)
        @(posedge sys_clk_i);
        #1 `CHK(rrst, 8'h00)
    endtask
    task automatic t_err();
        wr(SLC_IRQ_MASK, 32'h0000_0020);
        ev(8'h20, 8'h00);
        rd(8'h85);
        `CHK({d[27], irq_o}, 2'b11)
        wr(SLC_IRQ_STAT, 32'h0000_0020);
        @(posedge sys_clk_i);
        #1 `CHK(irq_o, 1'b0)
        wr(8'h85, 32'h0080_0000);
        rd(8'h85);
        `CHK(d[27], 1'b0)
        ev(8'h00, 8'h40);
        rd(8'h86);
        `CHK({d[27], irq_o}, 2'b10)
        rd(SLC_IRQ_STAT);
        `CHK(d, 32'h0000_0040)
        wr(SLC_IRQ_STAT, 32'h0000_0040);
    endtask
    task automatic t_stf();
        logic [4:0] c;
        for (int s = 0; s < 8; s++) begin
            c = 5'(s * 3 + 1);
            wr(8'(SLC_STF_BASE + s), {s < 4, 22'h3F_FFFF, s[0], 3'b111, c});
            `CHK(chan[lk[s]*5+:5], c)
            rd(8'(SLC_STF_BASE + s));
            `CHK(d, {s < 4, 22'h0, s[0], 3'b000, c})
        end
        `CHK({sen, sproc}, 16'h0FAA)
    endtask
    task automatic t_stat();
        @(posedge sys_clk_i);
        lvl <= 8'h96;
        repeat (3) @(posedge sys_clk_i);
        for (int n = 0; n < 8; n++) begin
            rd(8'(SLC_STAT_BASE + n));
            `CHK(d, {29'h0, lvl[n], ~lvl[n], lvl[n]})
            rd(8'(SLC_CFG_BASE + n));
            `CHK(d[26], lvl[n])
        end
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30);
        `CHK(d, 32'h0000_0000)
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            rd(8'(SLC_CFG_BASE + n));
            `CHK(d, 32'h0000_0000)
            rd(8'(SLC_STF_BASE + n));
            `CHK(d, 32'h0000_0000)
        end
        t_cfg();
        t_act();
        t_err();
        t_stf();
        t_stat();
        end_of_test();
    end
endmodule
`default_nettype wire
